// file: verilog/doppler_ctrl_pkg.sv
// package: register map, encodings, timing constants for the doppler mode/rate controller
// assumes: 40 MHz clock, axi4-lite register access, 32-bit data
package doppler_ctrl_pkg;

	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] LEVEL_OFF = 8'h04;
	localparam logic [7:0] PWM_DUTY_OFF = 8'h08;
	localparam logic [7:0] PWM_TIME_OFF = 8'h0c;
	localparam logic [7:0] PWM_HOLD_OFF = 8'h10;
	localparam logic [7:0] RATE_OFF = 8'h14;
	localparam logic [7:0] STATUS_OFF = 8'h18;

	// ****************************************
	// field positions
	// ****************************************
	localparam int OUT_MODE_LSB = 0;
	localparam int RUN_MODE_LSB = 2;
	localparam int SENS_EN_BIT = 4;
	localparam int AUTO_EN_BIT = 5;
	localparam int MAN_RATE_LSB = 8;
	localparam int SPEED_LSB = 12;
	localparam int REACT_LSB = 16;
	localparam int PWM_IDLE_LSB = 0;
	localparam int PWM_DET_LSB = 8;
	localparam int PWM_PERIOD_LSB = 16;
	localparam int FADE_IN_LSB = 0;
	localparam int FADE_OUT_LSB = 16;

	// ****************************************
	// encodings
	// ****************************************
	typedef enum logic [1:0] {OUT_LEVEL, OUT_PWM, OUT_UART} out_mode_type;
	typedef enum logic [1:0] {RUN_DETECT, RUN_SLEEP, RUN_DEEP} run_mode_type;
	// rate code 0..4 = 1,2,4,8,16 khz
	localparam logic [2:0] RATE_1K = 3'h0;
	localparam logic [2:0] RATE_2K = 3'h1;
	localparam logic [2:0] RATE_4K = 3'h2;
	localparam logic [2:0] RATE_16K = 3'h4;
	// speed code 0..7 = 0.39,0.52,0.77,1.55,3.10,6.20,12.40,24.80 m/s
	localparam logic [2:0] SPEED_1P55 = 3'h3;
	localparam logic [2:0] SPEED_3P10 = 3'h4;
	// sensitivity thresholds (percent) for 2,4,8,16 khz
	localparam logic [6:0] SENS_TH2 = 7'h28;
	localparam logic [6:0] SENS_TH4 = 7'h37;
	localparam logic [6:0] SENS_TH8 = 7'h46;
	localparam logic [6:0] SENS_TH16 = 7'h55;
	localparam logic [6:0] SENS_HYST = 7'h03;
	localparam logic [6:0] SENS_MAX = 7'h64;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [6:0] REACT_RST = 7'h07; // (n+1)*16 ms = 128 ms
	localparam logic [7:0] PWM_IDLE_RST = 8'h00;
	localparam logic [7:0] PWM_DET_RST = 8'hff;
	localparam logic [15:0] PWM_PERIOD_RST = 16'h03e8;
	localparam logic [15:0] FADE_RST = 16'h0064;
	localparam logic [15:0] HOLD_RST = 16'h03e8;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_HZ = 40000000;
	localparam int SLEEP_WAKE_MS = 100;
	localparam int DEEP_WAKE_MS = 600;
	localparam int REACT_STEP_MS = 16;
	localparam int RATE_CLEAR_MS = 160;
	localparam int MS_CYCLES = CLK_HZ / 1000;
	localparam int SLEEP_WAKE_CYCLES = SLEEP_WAKE_MS * MS_CYCLES;
	localparam int DEEP_WAKE_CYCLES = DEEP_WAKE_MS * MS_CYCLES;

endpackage

// file: verilog/doppler_ctrl.sv
// doppler sensor mode / rate controller with axi4-lite registers
// assumes: one 40 MHz clock; motion and sensitivity voltage code arrive asynchronously from the front end
//
// What this block does
// - output pin runs level, pwm or serial mode; level after reset
// - level mode drives pin high while motion detected, low otherwise
// - level mode: host chooses motion type and optional inversion
// - pwm mode duty ratio changes, triggered by detection
// - pwm frequency, fades, idle duty, detect duty, hold time are settable
// - serial mode: host reads detection, settings and operating status
// - running modes detect, sleep, deep sleep; detect after reset
// - detect mode keeps radio on and evaluates motion
// - sleep stops radio; return to detect takes 100 ms
// - deep sleep cuts analog power; leaving takes 600 ms
// - analog sensitivity input enable, enabled after reset
// - percent = ceil(v*1.2/3.3*100-10) clamped 0..100
// - rate change clears buffer, forces non-detect up to reaction+160 ms
// - radio rate: 1k->1k, 2k->2k, higher -> continuous
// - manual rate rejected when below speed minimum
// - automatic rate control, default on, picks rate itself
// - speed map: <=1.55 1k, 3.10 2k, 6.20 4k, 12.40 8k, 24.80 16k
// - sensitivity map: 0-39,40-54,55-69,70-84,85-100 to 1k..16k
// - automatic rate is the higher of both maps
// - analog input: raise at threshold, lower only 3 percent below
// - reaction time 16..2048 ms in 16 ms steps, motion must persist
// - target speed 1.55 m/s after reset
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module doppler_ctrl #(
	parameter int SLEEP_WAKE_CYC = doppler_ctrl_pkg::SLEEP_WAKE_CYCLES,
	parameter int DEEP_WAKE_CYC = doppler_ctrl_pkg::DEEP_WAKE_CYCLES,
	parameter int MS_CYC = doppler_ctrl_pkg::MS_CYCLES
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// axi4-lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// front end
	input wire logic approach_i,
	input wire logic leave_i,
	input wire logic [7:0] sens_voltage_code_i,
	// outputs
	output logic multi_mode_output_o,
	output logic radio_en_o,
	output logic continuous_transmission_o,
	output logic [2:0] radio_rate_o,
	output logic analog_power_en_o,
	output logic buffer_clear_o
);

	// ****************************************
	// register state
	// ****************************************
	doppler_ctrl_pkg::out_mode_type out_mode_reg;
	doppler_ctrl_pkg::run_mode_type run_mode_reg;
	logic sens_en_reg, auto_en_reg, invert_reg;
	logic [1:0] motion_sel_reg; // bit0 approach, bit1 leave
	logic [2:0] man_rate_reg, speed_reg, rate_reg;
	logic [6:0] react_reg, fixed_sens_reg;
	logic [7:0] pwm_idle_reg, pwm_det_reg;
	logic [15:0] pwm_period_reg, fade_in_reg, fade_out_reg, hold_reg;
	logic reject_reg;

	// ****************************************
	// input synchronisers
	// ****************************************
	logic [1:0] mot_s1_reg, mot_s2_reg;
	logic [7:0] vc_s1_reg, vc_s2_reg;
	always_ff @(posedge clk_i) begin
		mot_s1_reg <= {leave_i, approach_i};
		mot_s2_reg <= mot_s1_reg;
		vc_s1_reg <= sens_voltage_code_i;
		vc_s2_reg <= vc_s1_reg;
	end

	// ****************************************
	// analog sensitivity percent
	// ****************************************
	// code 0..255 = 0..3.3 v: pct = ceil(code*120/255 - 10); integer ceil via +254
	logic [15:0] sens_prod;
	logic [6:0] sens_pct;
	always_comb begin
		sens_prod = 16'(({8'h00, vc_s2_reg} * 16'h0078 + 16'h00fe) / 16'h00ff);
		if (sens_prod <= 16'h000a) sens_pct = 7'h00;
		else if (sens_prod - 16'h000a >= 16'(doppler_ctrl_pkg::SENS_MAX)) sens_pct = doppler_ctrl_pkg::SENS_MAX;
		else sens_pct = 7'(sens_prod - 16'h000a);
	end
	logic [6:0] analog_sensitivity_percent;
	assign analog_sensitivity_percent = sens_en_reg ? sens_pct : fixed_sens_reg;

	// ****************************************
	// rate selection
	// ****************************************
	logic [2:0] speed_rate, sens_rate, sens_rate_hyst, auto_rate, sens_rate_reg;
	always_comb begin
		speed_rate = (speed_reg <= doppler_ctrl_pkg::SPEED_1P55) ? doppler_ctrl_pkg::RATE_1K :
			3'(speed_reg - doppler_ctrl_pkg::SPEED_1P55);
		if (analog_sensitivity_percent >= doppler_ctrl_pkg::SENS_TH16) sens_rate = 3'h4;
		else if (analog_sensitivity_percent >= doppler_ctrl_pkg::SENS_TH8) sens_rate = 3'h3;
		else if (analog_sensitivity_percent >= doppler_ctrl_pkg::SENS_TH4) sens_rate = 3'h2;
		else if (analog_sensitivity_percent >= doppler_ctrl_pkg::SENS_TH2) sens_rate = 3'h1;
		else sens_rate = 3'h0;
		// hold the previous rate until 3 percent under its own threshold
		sens_rate_hyst = sens_rate;
		if (sens_en_reg && sens_rate < sens_rate_reg) begin
			case (sens_rate_reg)
				3'h1: if (analog_sensitivity_percent + doppler_ctrl_pkg::SENS_HYST > doppler_ctrl_pkg::SENS_TH2) sens_rate_hyst = 3'h1;
				3'h2: if (analog_sensitivity_percent + doppler_ctrl_pkg::SENS_HYST > doppler_ctrl_pkg::SENS_TH4) sens_rate_hyst = 3'h2;
				3'h3: if (analog_sensitivity_percent + doppler_ctrl_pkg::SENS_HYST > doppler_ctrl_pkg::SENS_TH8) sens_rate_hyst = 3'h3;
				3'h4: if (analog_sensitivity_percent + doppler_ctrl_pkg::SENS_HYST > doppler_ctrl_pkg::SENS_TH16) sens_rate_hyst = 3'h4;
				default: sens_rate_hyst = sens_rate;
			endcase
		end
		auto_rate = (speed_rate > sens_rate_hyst) ? speed_rate : sens_rate_hyst;
	end

	// applied rate; any change pulses the buffer clear
	logic [2:0] rate_next;
	assign rate_next = auto_en_reg ? auto_rate : man_rate_reg;
	logic rate_change;
	assign rate_change = (rate_next != rate_reg);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rate_reg <= doppler_ctrl_pkg::RATE_1K;
			sens_rate_reg <= doppler_ctrl_pkg::RATE_1K;
		end else begin
			rate_reg <= rate_next;
			sens_rate_reg <= sens_rate_hyst;
		end
	end

	// radio intermittent rate
	always_comb begin
		continuous_transmission_o = rate_reg >= doppler_ctrl_pkg::RATE_4K;
		radio_rate_o = rate_reg;
	end

	// ****************************************
	// running mode sequencer
	// ****************************************
	logic [31:0] wake_cnt_reg;
	logic deep_wake_reg;
	logic detect_active;
	assign detect_active = (run_mode_reg == doppler_ctrl_pkg::RUN_DETECT) && (wake_cnt_reg == 32'h0);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wake_cnt_reg <= 32'h0;
			deep_wake_reg <= 1'b0;
		end else if (run_mode_reg == doppler_ctrl_pkg::RUN_DEEP) begin
			deep_wake_reg <= 1'b1;
			wake_cnt_reg <= 32'(DEEP_WAKE_CYC);
		end else if (run_mode_reg == doppler_ctrl_pkg::RUN_SLEEP && !deep_wake_reg) begin
			wake_cnt_reg <= 32'(SLEEP_WAKE_CYC);
		end else if (wake_cnt_reg != 32'h0) begin
			wake_cnt_reg <= wake_cnt_reg - 32'h1;
		end else begin
			deep_wake_reg <= 1'b0;
		end
	end
	always_comb begin
		radio_en_o = detect_active;
		analog_power_en_o = (run_mode_reg != doppler_ctrl_pkg::RUN_DEEP);
	end

	// ****************************************
	// detection with reaction time
	// ****************************************
	// a rate change restarts the clear window: reaction + 160 ms of forced non-detect
	logic [15:0] ms_cnt_reg;
	logic [11:0] persist_ms_reg, clear_ms_reg;
	logic ms_tick, motion, detected_reg;
	assign ms_tick = (ms_cnt_reg == 16'(MS_CYC - 1));
	assign motion = |(mot_s2_reg & motion_sel_reg);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ms_cnt_reg <= 16'h0;
			persist_ms_reg <= 12'h0;
			clear_ms_reg <= 12'h0;
			detected_reg <= 1'b0;
		end else begin
			ms_cnt_reg <= ms_tick ? 16'h0 : ms_cnt_reg + 16'h1;
			if (rate_change) begin
				clear_ms_reg <= 12'(({5'h0, react_reg} + 12'h1) * 12'(doppler_ctrl_pkg::REACT_STEP_MS)
					+ 12'(doppler_ctrl_pkg::RATE_CLEAR_MS));
				persist_ms_reg <= 12'h0;
				detected_reg <= 1'b0;
			end else if (!detect_active) begin
				persist_ms_reg <= 12'h0;
				detected_reg <= 1'b0;
			end else if (ms_tick) begin
				if (clear_ms_reg != 12'h0) clear_ms_reg <= clear_ms_reg - 12'h1;
				if (!motion || clear_ms_reg != 12'h0) begin
					persist_ms_reg <= 12'h0;
					detected_reg <= 1'b0;
				end else begin
					if (persist_ms_reg != 12'hfff) persist_ms_reg <= persist_ms_reg + 12'h1;
					if (persist_ms_reg >= ({5'h0, react_reg} + 12'h1) * 12'(doppler_ctrl_pkg::REACT_STEP_MS))
						detected_reg <= 1'b1;
				end
			end
		end
	end
	assign buffer_clear_o = rate_change;

	// ****************************************
	// pwm fade engine
	// ****************************************
	typedef enum logic [1:0] {PWM_IDLE, PWM_FADE_IN, PWM_HOLD, PWM_FADE_OUT} pwm_state_type;
	pwm_state_type pwm_state_reg;
	logic [15:0] pwm_ms_reg, pwm_cnt_reg;
	logic [7:0] duty_reg;
	logic [23:0] span;
	logic [7:0] lo, hi, delta;
	always_comb begin
		lo = (pwm_det_reg > pwm_idle_reg) ? pwm_idle_reg : pwm_det_reg;
		hi = (pwm_det_reg > pwm_idle_reg) ? pwm_det_reg : pwm_idle_reg;
		delta = hi - lo;
		span = 24'h0;
		case (pwm_state_reg)
			PWM_FADE_IN: span = (fade_in_reg == 16'h0) ? 24'h0 :
				24'(({8'h0, delta} * {8'h0, pwm_ms_reg}) / {8'h0, fade_in_reg});
			PWM_FADE_OUT: span = (fade_out_reg == 16'h0) ? 24'h0 :
				24'(({8'h0, delta} * {8'h0, pwm_ms_reg}) / {8'h0, fade_out_reg});
			default: span = 24'h0;
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwm_state_reg <= PWM_IDLE;
			pwm_ms_reg <= 16'h0;
			duty_reg <= doppler_ctrl_pkg::PWM_IDLE_RST;
		end else begin
			case (pwm_state_reg)
				PWM_IDLE: begin
					duty_reg <= pwm_idle_reg;
					pwm_ms_reg <= 16'h0;
					if (detected_reg) pwm_state_reg <= PWM_FADE_IN;
				end
				PWM_FADE_IN: begin
					duty_reg <= (pwm_det_reg > pwm_idle_reg) ? 8'(lo + span[7:0]) : 8'(hi - span[7:0]);
					if (ms_tick) pwm_ms_reg <= pwm_ms_reg + 16'h1;
					if (pwm_ms_reg >= fade_in_reg) begin
						pwm_state_reg <= PWM_HOLD;
						pwm_ms_reg <= 16'h0;
					end
				end
				PWM_HOLD: begin
					duty_reg <= pwm_det_reg;
					if (detected_reg) pwm_ms_reg <= 16'h0; // hold counts from motion end
					else if (ms_tick) pwm_ms_reg <= pwm_ms_reg + 16'h1;
					if (!detected_reg && pwm_ms_reg >= hold_reg) begin
						pwm_state_reg <= PWM_FADE_OUT;
						pwm_ms_reg <= 16'h0;
					end
				end
				PWM_FADE_OUT: begin
					duty_reg <= (pwm_det_reg > pwm_idle_reg) ? 8'(hi - span[7:0]) : 8'(lo + span[7:0]);
					if (ms_tick) pwm_ms_reg <= pwm_ms_reg + 16'h1;
					if (detected_reg) begin
						pwm_state_reg <= PWM_FADE_IN;
						pwm_ms_reg <= 16'h0;
					end else if (pwm_ms_reg >= fade_out_reg) pwm_state_reg <= PWM_IDLE;
				end
				default: pwm_state_reg <= PWM_IDLE;
			endcase
		end
	end

	// carrier: period in clocks, duty in 1/255 of it
	logic [15:0] pwm_phase_reg;
	logic [23:0] pwm_thresh;
	logic pwm_out;
	assign pwm_thresh = 24'(({8'h0, pwm_period_reg} * {16'h0, duty_reg}) / 24'h0000ff);
	assign pwm_out = {8'h0, pwm_phase_reg} < pwm_thresh;
	always_ff @(posedge clk_i) begin
		if (rst_i) pwm_phase_reg <= 16'h0;
		else if (pwm_phase_reg + 16'h1 >= pwm_period_reg) pwm_phase_reg <= 16'h0;
		else pwm_phase_reg <= pwm_phase_reg + 16'h1;
	end

	// output pin
	always_ff @(posedge clk_i) begin
		if (rst_i) multi_mode_output_o <= 1'b0;
		else case (out_mode_reg)
			doppler_ctrl_pkg::OUT_LEVEL: multi_mode_output_o <= detected_reg ^ invert_reg;
			doppler_ctrl_pkg::OUT_PWM: multi_mode_output_o <= pwm_out;
			default: multi_mode_output_o <= 1'b0; // serial mode: status is read over the bus
		endcase
	end

	// ****************************************
	// axi4-lite slave
	// ****************************************
	logic aw_held_reg, w_held_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic wr_go;
	logic [31:0] wd;
	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go = aw_held_reg && w_held_reg;
	always_comb begin
		wd = 32'h0;
		for (int i = 0; i < 4; i++) wd[i*8 +: 8] = w_strb_reg[i] ? w_data_reg[i*8 +: 8] : 8'h00;
	end
	// rates below the minimum for the speed in the same write are rejected
	logic man_ok;
	assign man_ok = (wd[doppler_ctrl_pkg::SPEED_LSB +: 3] <= doppler_ctrl_pkg::SPEED_1P55) ||
		(wd[doppler_ctrl_pkg::MAN_RATE_LSB +: 3] >= 3'(wd[doppler_ctrl_pkg::SPEED_LSB +: 3] - doppler_ctrl_pkg::SPEED_1P55));

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_addr_reg <= 8'h0;
			w_data_reg <= 32'h0;
			w_strb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr_reg > doppler_ctrl_pkg::RATE_OFF) ? 2'b10 : 2'b00;
			end else if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
		end
	end

	// register writes; full-word fields, byte strobes mask the data
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_mode_reg <= doppler_ctrl_pkg::OUT_LEVEL;
			run_mode_reg <= doppler_ctrl_pkg::RUN_DETECT;
			sens_en_reg <= 1'b1;
			auto_en_reg <= 1'b1;
			man_rate_reg <= doppler_ctrl_pkg::RATE_1K;
			speed_reg <= doppler_ctrl_pkg::SPEED_1P55;
			react_reg <= doppler_ctrl_pkg::REACT_RST;
			motion_sel_reg <= 2'b11;
			invert_reg <= 1'b0;
			fixed_sens_reg <= doppler_ctrl_pkg::SENS_MAX;
			pwm_idle_reg <= doppler_ctrl_pkg::PWM_IDLE_RST;
			pwm_det_reg <= doppler_ctrl_pkg::PWM_DET_RST;
			pwm_period_reg <= doppler_ctrl_pkg::PWM_PERIOD_RST;
			fade_in_reg <= doppler_ctrl_pkg::FADE_RST;
			fade_out_reg <= doppler_ctrl_pkg::FADE_RST;
			hold_reg <= doppler_ctrl_pkg::HOLD_RST;
			reject_reg <= 1'b0;
		end else if (wr_go) begin
			case (aw_addr_reg)
				doppler_ctrl_pkg::CTRL_OFF: begin
					if (wd[doppler_ctrl_pkg::OUT_MODE_LSB +: 2] != 2'h3)
						out_mode_reg <= doppler_ctrl_pkg::out_mode_type'(wd[doppler_ctrl_pkg::OUT_MODE_LSB +: 2]);
					if (wd[doppler_ctrl_pkg::RUN_MODE_LSB +: 2] != 2'h3)
						run_mode_reg <= doppler_ctrl_pkg::run_mode_type'(wd[doppler_ctrl_pkg::RUN_MODE_LSB +: 2]);
					sens_en_reg <= wd[doppler_ctrl_pkg::SENS_EN_BIT];
					react_reg <= wd[doppler_ctrl_pkg::REACT_LSB +: 7];
					if (wd[doppler_ctrl_pkg::AUTO_EN_BIT] || (man_ok && wd[doppler_ctrl_pkg::MAN_RATE_LSB +: 3] <= doppler_ctrl_pkg::RATE_16K)) begin
						auto_en_reg <= wd[doppler_ctrl_pkg::AUTO_EN_BIT];
						speed_reg <= wd[doppler_ctrl_pkg::SPEED_LSB +: 3];
						man_rate_reg <= wd[doppler_ctrl_pkg::MAN_RATE_LSB +: 3];
						reject_reg <= 1'b0;
					end else reject_reg <= 1'b1;
				end
				doppler_ctrl_pkg::LEVEL_OFF: begin
					motion_sel_reg <= wd[1:0];
					invert_reg <= wd[2];
					fixed_sens_reg <= (wd[14:8] > doppler_ctrl_pkg::SENS_MAX) ? doppler_ctrl_pkg::SENS_MAX : wd[14:8];
				end
				doppler_ctrl_pkg::PWM_DUTY_OFF: begin
					pwm_idle_reg <= wd[doppler_ctrl_pkg::PWM_IDLE_LSB +: 8];
					pwm_det_reg <= wd[doppler_ctrl_pkg::PWM_DET_LSB +: 8];
					pwm_period_reg <= wd[doppler_ctrl_pkg::PWM_PERIOD_LSB +: 16];
				end
				doppler_ctrl_pkg::PWM_TIME_OFF: begin
					fade_in_reg <= wd[doppler_ctrl_pkg::FADE_IN_LSB +: 16];
					fade_out_reg <= wd[doppler_ctrl_pkg::FADE_OUT_LSB +: 16];
				end
				doppler_ctrl_pkg::PWM_HOLD_OFF: hold_reg <= wd[15:0];
				default: reject_reg <= reject_reg;
			endcase
		end
	end

	// reads: settings and live status
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'b00;
			case (s_axi_araddr)
				doppler_ctrl_pkg::CTRL_OFF: s_axi_rdata <= {9'h0, react_reg, 1'b0, speed_reg, 1'b0, man_rate_reg,
					2'h0, auto_en_reg, sens_en_reg, run_mode_reg, out_mode_reg};
				doppler_ctrl_pkg::LEVEL_OFF: s_axi_rdata <= {17'h0, fixed_sens_reg, 5'h0, invert_reg, motion_sel_reg};
				doppler_ctrl_pkg::PWM_DUTY_OFF: s_axi_rdata <= {pwm_period_reg, pwm_det_reg, pwm_idle_reg};
				doppler_ctrl_pkg::PWM_TIME_OFF: s_axi_rdata <= {fade_out_reg, fade_in_reg};
				doppler_ctrl_pkg::PWM_HOLD_OFF: s_axi_rdata <= {16'h0, hold_reg};
				doppler_ctrl_pkg::RATE_OFF: s_axi_rdata <= {21'h0, analog_sensitivity_percent, 1'b0, rate_reg};
				doppler_ctrl_pkg::STATUS_OFF: s_axi_rdata <= {26'h0, reject_reg, clear_ms_reg != 12'h0,
					detect_active, mot_s2_reg[1] & detected_reg, mot_s2_reg[0] & detected_reg, detected_reg};
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= 2'b10;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
	end

endmodule
`default_nettype wire

// file: dv/doppler_ctrl_props.sv
// checker: port-level properties of the doppler controller
// assumes: bound to the controller; one clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module doppler_ctrl_props (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// pins
	input wire logic radio_en_o,
	input wire logic continuous_transmission_o,
	input wire logic [2:0] radio_rate_o,
	input wire logic analog_power_en_o,
	input wire logic buffer_clear_o
);
	// ********
	// properties
	// ********
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	cont_rate_a: assert property (continuous_transmission_o == (radio_rate_o > 3'h1))
		else $error("continuous flag disagrees with rate");
	rate_code_a: assert property (radio_rate_o <= 3'h4)
		else $error("rate code out of range");
	clear_pulse_a: assert property (buffer_clear_o |=> !buffer_clear_o)
		else $error("buffer clear longer than one cycle");
	clear_rate_a: assert property ($changed(radio_rate_o) |-> buffer_clear_o || $past(buffer_clear_o))
		else $error("rate changed without buffer clear");
	radio_power_a: assert property (radio_en_o |-> analog_power_en_o)
		else $error("radio on without analog power");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	cover property (buffer_clear_o);
	cover property (!radio_en_o);
	cover property (s_axi_rvalid && !s_axi_rready);
endmodule
bind doppler_ctrl doppler_ctrl_props i_doppler_ctrl_props (.*);
`default_nettype wire

// file: dv/host_model.sv
// host model: axi4-lite master for the register port
// assumes: bench timeout cuts a hang; a response is always taken one cycle late
`timescale 1ns/1ps
`default_nettype none
module host_model (
	// clock
	input wire logic clk_i,
	// write
	output logic [7:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	// read
	output logic [7:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	// idle bus; ready raised late so the slave must hold its answer
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		forever begin
			@(posedge clk_i);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bready && s_axi_bvalid) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
			if (s_axi_bvalid) s_axi_bready <= 1'b1;
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		forever begin
			@(posedge clk_i);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rready && s_axi_rvalid) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
			if (s_axi_rvalid) s_axi_rready <= 1'b1;
		end
	endtask
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// bench: drives the controller through registers and front end, checks pins and registers
// assumes: shortened wake and millisecond counts keep the run under ten thousand cycles
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk_i, rst_i, approach_i, leave_i;
	logic [7:0] sens_voltage_code_i, s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic multi_mode_output_o, radio_en_o, continuous_transmission_o, analog_power_en_o, buffer_clear_o;
	logic [2:0] radio_rate_o, ex;
	logic [7:0] codes [3] = '{8'h69, 8'h62, 8'h60}; // percent 40, 37, 36
	int num_errors, cmp_count, cycles, seed, pv, p;
	doppler_ctrl #(.SLEEP_WAKE_CYC(40), .DEEP_WAKE_CYC(100), .MS_CYC(20)) i_doppler_ctrl (.*);
	host_model i_host_model (.*);
	// ********
	// helpers
	// ********
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic complete_run;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	function automatic int pct(input logic [7:0] c);
		int v;
		v = (int'(c) * 120 + 254) / 255 - 10;
		return (v < 0) ? 0 : ((v > 100) ? 100 : v);
	endfunction
	function automatic logic [2:0] rmap(input int q);
		return (q >= 85) ? 3'h4 : (q >= 70) ? 3'h3 : (q >= 55) ? 3'h2 : (q >= 40) ? 3'h1 : 3'h0;
	endfunction
	// clock and hang guard
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			complete_run();
		end
	end
	// main sequence; hysteresis corners first, then random voltages
	initial begin
		seed = 32'ha81dafe5;
		rst_i = 1'b1;
		approach_i = 1'b0;
		leave_i = 1'b0;
		sens_voltage_code_i = 8'h00;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		i_host_model.rd(doppler_ctrl_pkg::CTRL_OFF, d, r);
		chk("ctrl", 32'h00073030, d);
		chk("pins", 32'h3, {30'h0, radio_en_o, analog_power_en_o});
		i_host_model.rd(8'h40, d, r);
		chk("rresp", 32'h2, {30'h0, r});
		pv = 0;
		for (int i = 0; i < 20; i++) begin
			sens_voltage_code_i <= (i < 3) ? codes[i] : 8'($random(seed));
			repeat (12) @(posedge clk_i);
			p = pct(sens_voltage_code_i);
			ex = (rmap(p) >= pv) ? rmap(p) : ((rmap(p + 2) < pv) ? rmap(p + 2) : 3'(pv));
			pv = int'(ex);
			chk("rate", {29'h0, ex}, {29'h0, radio_rate_o});
			chk("cont", {31'h0, ex > 3'h1}, {31'h0, continuous_transmission_o});
		end
		i_host_model.wr(doppler_ctrl_pkg::CTRL_OFF, 32'h00007030, r);
		repeat (12) @(posedge clk_i);
		chk("rate", 32'h4, {29'h0, radio_rate_o});
		i_host_model.wr(doppler_ctrl_pkg::CTRL_OFF, 32'h00007110, r);
		i_host_model.rd(doppler_ctrl_pkg::STATUS_OFF, d, r);
		chk("reject", 32'h1, {31'h0, d[5]});
		chk("rate", 32'h4, {29'h0, radio_rate_o});
		i_host_model.wr(doppler_ctrl_pkg::CTRL_OFF, 32'h00003110, r);
		repeat (4) @(posedge clk_i);
		chk("rate", 32'h1, {29'h0, radio_rate_o});
		approach_i <= 1'b1;
		repeat (9000) @(posedge clk_i);
		chk("mmo", 32'h1, {31'h0, multi_mode_output_o});
		i_host_model.wr(doppler_ctrl_pkg::LEVEL_OFF, 32'h00006407, r);
		repeat (4) @(posedge clk_i);
		chk("mmo", 32'h0, {31'h0, multi_mode_output_o});
		approach_i <= 1'b0;
		repeat (25) @(posedge clk_i);
		chk("mmo", 32'h1, {31'h0, multi_mode_output_o});
		i_host_model.wr(doppler_ctrl_pkg::CTRL_OFF, 32'h00003114, r);
		repeat (3) @(posedge clk_i);
		chk("radio", 32'h0, {31'h0, radio_en_o});
		i_host_model.wr(doppler_ctrl_pkg::CTRL_OFF, 32'h00003110, r);
		repeat (30) @(posedge clk_i);
		chk("radio", 32'h0, {31'h0, radio_en_o});
		repeat (20) @(posedge clk_i);
		chk("radio", 32'h1, {31'h0, radio_en_o});
		i_host_model.wr(doppler_ctrl_pkg::CTRL_OFF, 32'h00003118, r);
		repeat (3) @(posedge clk_i);
		chk("power", 32'h0, {31'h0, analog_power_en_o});
		complete_run();
	end
endmodule
`default_nettype wire
